// [src/curve_if.sv]
// carrier between the run controller and the v/f curve stage
`timescale 1ns/10ps
`default_nettype none
interface curve_if;
    import drive_pkg::*;
    freq_t  freq;
    curve_e shape;
    volt_t  v_max;
    freq_t  f_base;
    volt_t  v_mid;
    freq_t  f_mid;
    volt_t  v_min;
    freq_t  f_min;
    volt_t  volt;
    modport ctrl  (output freq, shape, v_max, f_base, v_mid, f_mid, v_min, f_min, input volt);
    modport curve (input freq, shape, v_max, f_base, v_mid, f_mid, v_min, f_min, output volt);
endinterface
`default_nettype wire

// [src/drive_params.svh]
// constants for the run-command and frequency ramp logic
`ifndef DRIVE_PARAMS_SVH
`define DRIVE_PARAMS_SVH
`define FUNC_FWD_START  5'h06
`define FUNC_REV_START  5'h07
`define FUNC_STOP_3WIRE 5'h09
`define FUNC_ALT_RAMP   5'h0A
`define STOP_LOCK_RST   1'b1
`define REV_RST         1'b0
`define FREQ_CEILING    17'h18696
`define MCLK_HZ         125000000
`define ENTER_HOLD_MS   2000
`define RAMP_UNIT_MS    100
`endif

// [src/drive_pkg.sv]
// types and helpers shared by the run controller and the curve stage
package drive_pkg;
    typedef logic [16:0] freq_t;
    typedef logic [12:0] volt_t;
    typedef logic [13:0] ramp_t;
    typedef enum logic [1:0] {
        SRC_PANEL = 2'b00,
        SRC_TERM  = 2'b01,
        SRC_HOST  = 2'b10
    } run_src_e;
    typedef enum logic {
        CURVE_LINEAR = 1'b0,
        CURVE_POINTS = 1'b1
    } curve_e;

    // upper bound wins when the bounds are crossed
    function automatic freq_t clamp_val(freq_t x, freq_t lo, freq_t hi);
        freq_t r;
        r = (x < lo) ? lo : x;
        clamp_val = (r > hi) ? hi : r;
    endfunction
endpackage

// [src/drive_run_ctrl.sv]
// run-command latching, stop-key lockout, frequency ramp and curve hookup
//
// Notes on behaviour
// - three-wire: direction inputs only start pulses
// - start pulse released latches run and direction
// - three-wire stop input low clears run latch
// - selector codes 6, 7, 9 supported
// - source 1 takes commands from terminals
// - source 2 takes commands from host
// - lockout 1 stop key stops, 0 ignored
// - lockout change on enter, disable needs hold
// - after stop key, terminal needs re-assert
// - reverse permit 0 freezes direction
// - output frequency capped at maximum setting
// - set frequency raised to minimum setting
// - accel time spans zero to maximum
// - decel time spans maximum to zero
// - terminal selects alternate ramp pair
// - six settings define the v/f curve
// - curve voltages kept in order
// - curve frequencies kept in order
// - constant torque: voltage linear in frequency
// - two-wire: both off stops, both keep
`timescale 1ns/10ps
`default_nettype none
`include "drive_params.svh"
module drive_run_ctrl
    import drive_pkg::*;
#(
    parameter int ENTER_HOLD_CYC = `ENTER_HOLD_MS * (`MCLK_HZ / 1000),
    parameter int RAMP_UNIT_CYC  = `RAMP_UNIT_MS * (`MCLK_HZ / 1000)
)(
    input  wire logic        mclk,                   // system clock
    input  wire logic        rst,                    // synchronous reset
    input  wire logic        digital_input_1,        // terminal pin
    input  wire logic        digital_input_2,        // terminal pin
    input  wire logic        digital_input_3,        // terminal pin
    input  wire logic [4:0]  input1_function_select, // terminal 1 role
    input  wire logic [4:0]  input2_function_select, // terminal 2 role
    input  wire logic [4:0]  input3_function_select, // terminal 3 role
    input  wire logic [1:0]  run_source_select,      // 0 panel 1 terminal 2 host
    input  wire logic        panel_run_key,          // run key pulse
    input  wire logic        panel_stop_key,         // stop key pulse
    input  wire logic        panel_enter_key,        // enter key level
    input  wire logic        panel_reverse,          // panel direction
    input  wire logic        host_cmd_valid,         // host command pulse
    input  wire logic        host_run,               // host run request
    input  wire logic        host_reverse,           // host direction
    input  wire logic        stop_key_lockout,       // pending lockout value
    input  wire logic        reverse_permit,         // 1 allows reversal
    input  wire logic [16:0] set_freq,               // 0.01 Hz
    input  wire logic [16:0] max_output_freq,        // 0.01 Hz
    input  wire logic [16:0] min_output_freq,        // 0.01 Hz
    input  wire logic [13:0] accel_time,             // 0.1 s
    input  wire logic [13:0] decel_time,             // 0.1 s
    input  wire logic [13:0] alt_accel_time,         // 0.1 s
    input  wire logic [13:0] alt_decel_time,         // 0.1 s
    input  wire logic        curve_shape,            // 0 linear 1 points
    input  wire logic [12:0] curve_max_voltage,      // 0.1 V
    input  wire logic [16:0] curve_base_freq,        // 0.01 Hz
    input  wire logic [12:0] curve_mid_voltage,      // 0.1 V
    input  wire logic [16:0] curve_mid_freq,         // 0.01 Hz
    input  wire logic [12:0] curve_min_voltage,      // 0.1 V
    input  wire logic [16:0] curve_min_freq,         // 0.01 Hz
    output logic             run_active,             // running or ramping
    output logic [16:0]      out_freq,               // 0.01 Hz
    output logic             out_reverse,            // output direction
    output logic [12:0]      out_voltage,            // 0.1 V
    output logic             stop_key_active         // stop key effective
);
    localparam logic [27:0] HOLD_LAST = 28'(ENTER_HOLD_CYC - 1);

    // ------------------------------------------------------------
    // terminal pins
    // ------------------------------------------------------------
    logic [2:0] sync1_q;
    logic [2:0] sync2_q;
    logic [2:0] sync3_q;
    logic [2:0] pin_q;
    logic [2:0] pin_d;
    logic [2:0] agree;

    always_comb begin
        agree = ~(sync2_q ^ sync3_q);
        pin_d = (pin_q & ~agree) | (sync3_q & agree);
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            sync1_q <= 3'h0;
            sync2_q <= 3'h0;
            sync3_q <= 3'h0;
            pin_q   <= 3'h0;
        end else begin
            sync1_q <= {digital_input_3, digital_input_2, digital_input_1};
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            pin_q   <= pin_d;
        end
    end

    function automatic logic [2:0] func_mask(logic [4:0] code);
        func_mask = {input3_function_select == code,
                     input2_function_select == code,
                     input1_function_select == code};
    endfunction

    logic fwd_lvl;
    logic rev_lvl;
    logic stop3_lvl;
    logic three_wire;
    logic alt_lvl;
    logic fwd_prev_q;
    logic rev_prev_q;
    logic fwd_fall;
    logic rev_fall;

    always_comb begin
        fwd_lvl    = |(func_mask(`FUNC_FWD_START) & pin_q);
        rev_lvl    = |(func_mask(`FUNC_REV_START) & pin_q);
        stop3_lvl  = |(func_mask(`FUNC_STOP_3WIRE) & pin_q);
        three_wire = |func_mask(`FUNC_STOP_3WIRE);
        alt_lvl    = |(func_mask(`FUNC_ALT_RAMP) & pin_q);
        fwd_fall   = fwd_prev_q & ~fwd_lvl;
        rev_fall   = rev_prev_q & ~rev_lvl;
    end

    // ------------------------------------------------------------
    // stop-key lockout
    // ------------------------------------------------------------
    logic        lock_q;
    logic        lock_d;
    logic        enter_prev_q;
    logic [27:0] hold_cnt_q;
    logic [27:0] hold_cnt_d;
    logic        stop_hit;

    // disabling needs a long hold so a brushed key cannot kill the stop key
    always_comb begin
        lock_d     = lock_q;
        hold_cnt_d = 28'h0000000;
        if (panel_enter_key) begin
            hold_cnt_d = (hold_cnt_q == HOLD_LAST) ? hold_cnt_q : hold_cnt_q + 28'h0000001;
            if (!enter_prev_q && stop_key_lockout) begin
                lock_d = 1'b1;
            end
            if (!stop_key_lockout && hold_cnt_q == HOLD_LAST) begin
                lock_d = 1'b0;
            end
        end
        stop_hit = panel_stop_key & lock_q;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            lock_q       <= `STOP_LOCK_RST;
            enter_prev_q <= 1'b0;
            hold_cnt_q   <= 28'h0000000;
        end else begin
            lock_q       <= lock_d;
            enter_prev_q <= panel_enter_key;
            hold_cnt_q   <= hold_cnt_d;
        end
    end

    // ------------------------------------------------------------
    // run request and direction
    // ------------------------------------------------------------
    logic run_q;
    logic run_d;
    logic dir_q;
    logic dir_d;
    logic hold_q;
    logic hold_d;
    logic want_rev;

    always_comb begin
        run_d    = run_q;
        hold_d   = hold_q;
        want_rev = dir_q;
        case (run_source_select)
            SRC_PANEL: begin
                hold_d = 1'b0;
                if (panel_run_key) begin
                    run_d    = 1'b1;
                    want_rev = panel_reverse;
                end
            end
            SRC_TERM: begin
                if (three_wire) begin
                    hold_d = 1'b0;
                    if (!stop3_lvl) begin
                        run_d = 1'b0;
                    end else if (fwd_fall) begin
                        run_d    = 1'b1;
                        want_rev = 1'b0;
                    end else if (rev_fall) begin
                        run_d    = 1'b1;
                        want_rev = 1'b1;
                    end
                end else if (hold_q) begin
                    run_d = 1'b0;
                    if (!fwd_lvl && !rev_lvl) begin
                        hold_d = 1'b0;
                    end
                end else if (fwd_lvl && !rev_lvl) begin
                    run_d    = 1'b1;
                    want_rev = 1'b0;
                end else if (rev_lvl && !fwd_lvl) begin
                    run_d    = 1'b1;
                    want_rev = 1'b1;
                end else if (!fwd_lvl && !rev_lvl) begin
                    run_d = 1'b0;
                end
            end
            SRC_HOST: begin
                hold_d = 1'b0;
                if (host_cmd_valid) begin
                    run_d    = host_run;
                    want_rev = host_reverse;
                end
            end
            default: begin
                run_d  = 1'b0;
                hold_d = 1'b0;
            end
        endcase
        dir_d = reverse_permit ? want_rev : dir_q;
        if (stop_hit) begin
            run_d  = 1'b0;
            hold_d = (run_source_select == SRC_TERM) && !three_wire;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            run_q      <= 1'b0;
            dir_q      <= `REV_RST;
            hold_q     <= 1'b0;
            fwd_prev_q <= 1'b0;
            rev_prev_q <= 1'b0;
        end else begin
            run_q      <= run_d;
            dir_q      <= dir_d;
            hold_q     <= hold_d;
            fwd_prev_q <= fwd_lvl;
            rev_prev_q <= rev_lvl;
        end
    end

    // ------------------------------------------------------------
    // frequency ramp
    // ------------------------------------------------------------
    freq_t       freq_q;
    freq_t       freq_d;
    freq_t       max_c;
    freq_t       tgt;
    logic        orev_q;
    logic        orev_d;
    logic        active_q;
    ramp_t       ramp_sel;
    logic [37:0] acc_q;
    logic [37:0] acc_d;
    logic [37:0] acc_sum;
    logic [37:0] lim;

    // bresenham stepping: one 0.01 Hz step per overflow, no divider needed
    always_comb begin
        max_c = (max_output_freq > `FREQ_CEILING) ? `FREQ_CEILING : max_output_freq;
        tgt   = 17'h00000;
        if (run_q && dir_q == orev_q) begin
            tgt = clamp_val(set_freq, min_output_freq, max_c);
        end
        if (freq_q < tgt) begin
            ramp_sel = alt_lvl ? alt_accel_time : accel_time;
        end else begin
            ramp_sel = alt_lvl ? alt_decel_time : decel_time;
        end
        lim     = 38'(ramp_sel) * 38'(RAMP_UNIT_CYC);
        acc_sum = acc_q + 38'(max_c) + 38'(max_c == 17'h00000);
        freq_d  = freq_q;
        orev_d  = orev_q;
        acc_d   = acc_sum;
        if (freq_q == tgt) begin
            acc_d = 38'h0000000000;
            if (freq_q == 17'h00000) begin
                orev_d = dir_q;
            end
        end else if (acc_sum >= lim) begin
            acc_d  = acc_sum - lim;
            freq_d = (freq_q < tgt) ? freq_q + 17'h00001 : freq_q - 17'h00001;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            freq_q   <= 17'h00000;
            orev_q   <= `REV_RST;
            acc_q    <= 38'h0000000000;
            active_q <= 1'b0;
        end else begin
            freq_q   <= freq_d;
            orev_q   <= orev_d;
            acc_q    <= acc_d;
            active_q <= run_d | (freq_d != 17'h00000);
        end
    end

    // ------------------------------------------------------------
    // curve stage and outputs
    // ------------------------------------------------------------
    curve_if cif ();
    assign cif.freq   = freq_q;
    assign cif.shape  = curve_e'(curve_shape);
    assign cif.v_max  = curve_max_voltage;
    assign cif.f_base = curve_base_freq;
    assign cif.v_mid  = curve_mid_voltage;
    assign cif.f_mid  = curve_mid_freq;
    assign cif.v_min  = curve_min_voltage;
    assign cif.f_min  = curve_min_freq;

    vf_curve u_curve (
        .mclk (mclk),
        .rst  (rst),
        .cv   (cif.curve)
    );

    assign run_active      = active_q;
    assign out_freq        = freq_q;
    assign out_reverse     = orev_q;
    assign out_voltage     = cif.volt;
    assign stop_key_active = lock_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    sequence s_fwd_pulse;
        run_source_select == SRC_TERM && three_wire && stop3_lvl && fwd_lvl
        ##1 run_source_select == SRC_TERM && three_wire && stop3_lvl && !fwd_lvl && !stop_hit;
    endsequence

    property p_start_latch;
        s_fwd_pulse |=> run_q ##1 (run_q || !stop3_lvl || stop_hit || run_source_select != SRC_TERM);
    endproperty
    a_start_latch: assert property (p_start_latch) else $error("start pulse did not latch run");

    property p_press_only;
        run_source_select == SRC_TERM && three_wire && !run_q && fwd_lvl && fwd_prev_q && !rev_fall
        |=> !run_q;
    endproperty
    a_press_only: assert property (p_press_only) else $error("held start input started run");

    property p_stop3;
        run_source_select == SRC_TERM && three_wire && !stop3_lvl |=> !run_q;
    endproperty
    a_stop3: assert property (p_stop3) else $error("stop input did not clear run");

    property p_key_locked;
        !lock_q && run_q && (run_source_select == SRC_PANEL
            || (run_source_select == SRC_HOST && !host_cmd_valid)) |=> run_q;
    endproperty
    a_key_locked: assert property (p_key_locked) else $error("blocked stop key halted run");

    property p_unlock_hold;
        $fell(lock_q) |-> $past(panel_enter_key) && $past(hold_cnt_q) == HOLD_LAST;
    endproperty
    a_unlock_hold: assert property (p_unlock_hold) else $error("stop key disabled without hold");

    property p_no_reverse;
        !reverse_permit |=> dir_q == $past(dir_q);
    endproperty
    a_no_reverse: assert property (p_no_reverse) else $error("direction changed while reverse barred");

    property p_cap;
        1'b1 |=> freq_q <= $past(freq_q) || freq_q <= $past(max_output_freq);
    endproperty
    a_cap: assert property (p_cap) else $error("output rose past maximum");

    property p_floor;
        run_q && dir_q == orev_q && min_output_freq <= max_c |-> tgt >= min_output_freq;
    endproperty
    a_floor: assert property (p_floor) else $error("target below minimum");

    property p_step;
        1'b1 |=> freq_q == $past(freq_q) || freq_q == $past(freq_q) + 17'h00001
                 || freq_q == $past(freq_q) - 17'h00001;
    endproperty
    a_step: assert property (p_step) else $error("ramp jumped more than one step");

    property p_two_wire_off;
        run_source_select == SRC_TERM && !three_wire && !fwd_lvl && !rev_lvl |=> !run_q;
    endproperty
    a_two_wire_off: assert property (p_two_wire_off) else $error("two-wire idle did not stop");
endmodule
`default_nettype wire

// [src/vf_curve.sv]
// output voltage from output frequency along the v/f curve
`timescale 1ns/10ps
`default_nettype none
module vf_curve
    import drive_pkg::*;
(
    input  wire logic mclk, // system clock
    input  wire logic rst,  // synchronous reset
    curve_if.curve    cv    // curve settings in, voltage out
);
    volt_t v_min_c;
    volt_t v_mid_c;
    freq_t f_min_c;
    freq_t f_mid_c;
    volt_t volt_d;
    volt_t volt_q;

    // callers guarantee f0 <= f <= f1 and v0 <= v1
    function automatic volt_t interp(freq_t f, freq_t f0, freq_t f1, volt_t v0, volt_t v1);
        logic [29:0] num;
        logic [29:0] span;
        num  = 30'(f - f0) * 30'(v1 - v0);
        span = 30'(f1 - f0);
        if (f1 <= f0) begin
            interp = v1;
        end else begin
            interp = v0 + 13'(num / span);
        end
    endfunction

    always_comb begin
        v_min_c = (cv.v_min > cv.v_max) ? cv.v_max : cv.v_min;
        v_mid_c = 13'(clamp_val(17'(cv.v_mid), 17'(v_min_c), 17'(cv.v_max)));
        f_min_c = (cv.f_min > cv.f_base) ? cv.f_base : cv.f_min;
        f_mid_c = clamp_val(cv.f_mid, f_min_c, cv.f_base);
        if (cv.freq == 17'h00000) begin
            volt_d = 13'h0000;
        end else if (cv.freq >= cv.f_base) begin
            volt_d = cv.v_max;
        end else if (cv.shape == CURVE_LINEAR) begin
            volt_d = interp(cv.freq, 17'h00000, cv.f_base, 13'h0000, cv.v_max);
        end else if (cv.freq >= f_mid_c) begin
            volt_d = interp(cv.freq, f_mid_c, cv.f_base, v_mid_c, cv.v_max);
        end else if (cv.freq >= f_min_c) begin
            volt_d = interp(cv.freq, f_min_c, f_mid_c, v_min_c, v_mid_c);
        end else begin
            volt_d = v_min_c;
        end
    end

    always_ff @(posedge mclk) begin
        volt_q <= rst ? 13'h0000 : volt_d;
    end
    assign cv.volt = volt_q;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    property p_above_base;
        cv.freq >= cv.f_base && cv.freq != 17'h00000 |=> volt_q == $past(cv.v_max);
    endproperty
    a_above_base: assert property (p_above_base) else $error("voltage not held at max above base");

    property p_volt_cap;
        1'b1 |=> volt_q <= $past(cv.v_max);
    endproperty
    a_volt_cap: assert property (p_volt_cap) else $error("voltage above curve maximum");
endmodule
`default_nettype wire

// [tb/drive_operator_model.sv]
// operator switch model for the three terminal pins
`timescale 1ns/10ps
`default_nettype none
module drive_operator_model (
    input  wire logic mclk,      // system clock
    output logic      term_fwd,  // forward switch
    output logic      term_rev,  // reverse switch
    output logic      term_stop  // stop switch, closed is high
);
    initial begin
        term_fwd = 1'b0;
        term_rev = 1'b0;
        term_stop = 1'b0;
    end
    // ------------------------------------------------------------
    // momentary press, held long enough to pass the pin filter
    // ------------------------------------------------------------
    task automatic pulse(input logic rev);
        @(negedge mclk);
        if (rev) term_rev = 1'b1;
        else term_fwd = 1'b1;
        repeat (8) @(negedge mclk);
        term_fwd = 1'b0;
        term_rev = 1'b0;
    endtask
    task automatic set_stop(input logic lvl);
        @(negedge mclk);
        term_stop = lvl;
    endtask
    task automatic set_dir(input logic fwd, input logic rev);
        @(negedge mclk);
        term_fwd = fwd;
        term_rev = rev;
    endtask
endmodule
`default_nettype wire

// [tb/test_drive_run_ctrl.sv]
// self-checking bench for the run controller
`timescale 1ns/10ps
`default_nettype none
module test_drive_run_ctrl;
    import drive_pkg::*;
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic [4:0]  sel1 = 5'h06, sel2 = 5'h07, sel3 = 5'h09;
    logic [1:0]  src = 2'h1;
    logic        run_key = 1'b0, stop_key = 1'b0, enter = 1'b0, pan_rev = 1'b0;
    logic        h_valid = 1'b0, h_run = 1'b0, h_rev = 1'b0, lockout = 1'b1, rev_ok = 1'b1;
    logic [16:0] set_f = 17'h000C8, max_f = 17'h00064, min_f = 17'h00000;
    logic [13:0] acc_t = 14'h0001, dec_t = 14'h0001, alt_acc = 14'h0002, alt_dec = 14'h0002;
    logic [12:0] c_vmax = 13'h0ED8, c_vmid = 13'h0100, c_vmin = 13'h0096;
    logic [16:0] c_fbase = 17'h01388, c_fmid = 17'h000FA, c_fmin = 17'h0007D;
    logic        shape = 1'b0;
    wire         t_fwd, t_rev, t_stop, run_active, out_reverse, stop_key_active;
    wire  [16:0] out_freq;
    wire  [12:0] out_voltage;
    int          err_total = 0;
    int          n_tests = 0;

    always #4 mclk = ~mclk;

    drive_operator_model u_op (.mclk(mclk), .term_fwd(t_fwd), .term_rev(t_rev), .term_stop(t_stop));

    drive_run_ctrl #(.ENTER_HOLD_CYC(16), .RAMP_UNIT_CYC(8)) u_dut (
        .mclk(mclk), .rst(rst),
        .digital_input_1(t_fwd), .digital_input_2(t_rev), .digital_input_3(t_stop),
        .input1_function_select(sel1), .input2_function_select(sel2), .input3_function_select(sel3),
        .run_source_select(src), .panel_run_key(run_key), .panel_stop_key(stop_key),
        .panel_enter_key(enter), .panel_reverse(pan_rev), .host_cmd_valid(h_valid),
        .host_run(h_run), .host_reverse(h_rev), .stop_key_lockout(lockout), .reverse_permit(rev_ok),
        .set_freq(set_f), .max_output_freq(max_f), .min_output_freq(min_f),
        .accel_time(acc_t), .decel_time(dec_t), .alt_accel_time(alt_acc), .alt_decel_time(alt_dec),
        .curve_shape(shape), .curve_max_voltage(c_vmax), .curve_base_freq(c_fbase),
        .curve_mid_voltage(c_vmid), .curve_mid_freq(c_fmid), .curve_min_voltage(c_vmin),
        .curve_min_freq(c_fmin), .run_active(run_active), .out_freq(out_freq),
        .out_reverse(out_reverse), .out_voltage(out_voltage), .stop_key_active(stop_key_active));

    task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // bounded waits: with the starting ramp times one step per cycle, so a full ramp needs about max_f cycles
    task automatic wait_run(input logic want);
        for (int i = 0; i < 400 && run_active !== want; i++) @(negedge mclk);
    endtask
    task automatic wait_freq(input logic [16:0] f);
        for (int i = 0; i < 400 && out_freq !== f; i++) @(negedge mclk);
    endtask
    task automatic tap(ref logic k);
        @(negedge mclk);
        k = 1'b1;
        @(negedge mclk);
        k = 1'b0;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic three_wire();
        u_op.set_stop(1'b1);
        u_op.pulse(1'b0);
        chk(run_active, 1'b0);
        wait_run(1'b1);
        chk(run_active, 1'b1);
        chk(out_reverse, 1'b0);
        wait_freq(max_f);
        chk(out_freq, 17'h00064);
        u_op.pulse(1'b1);
        for (int i = 0; i < 500 && out_reverse !== 1'b1; i++) @(negedge mclk);
        chk(out_reverse, 1'b1);
        wait_freq(max_f);
        chk(out_freq, 17'h00064);
        rev_ok = 1'b0;
        u_op.pulse(1'b0);
        repeat (40) @(negedge mclk);
        chk(out_reverse, 1'b1);
        rev_ok = 1'b1;
        u_op.set_stop(1'b0);
        wait_run(1'b0);
        chk(run_active, 1'b0);
        chk(out_freq, 17'h00000);
    endtask

    task automatic lockout_keys();
        src = 2'h0;
        tap(run_key);
        chk(run_active, 1'b1);
        lockout = 1'b0;
        enter = 1'b1;
        repeat (20) @(negedge mclk);
        enter = 1'b0;
        chk(stop_key_active, 1'b0);
        tap(stop_key);
        repeat (5) @(negedge mclk);
        chk(run_active, 1'b1);
        lockout = 1'b1;
        tap(enter);
        chk(stop_key_active, 1'b1);
        tap(stop_key);
        wait_run(1'b0);
        chk(out_freq, 17'h00000);
    endtask

    task automatic host_min();
        src = 2'h2;
        min_f = 17'h00032;
        set_f = 17'h0000A;
        h_run = 1'b1;
        h_rev = 1'b1;
        tap(h_valid);
        chk(run_active, 1'b1);
        wait_freq(17'h00032);
        chk(out_freq, 17'h00032);
        chk(out_reverse, 1'b1);
        h_run = 1'b0;
        tap(h_valid);
        wait_run(1'b0);
        chk(run_active, 1'b0);
    endtask

    // two-wire levels on pins 1 and 2; pin 3 picks the alternate ramp pair
    task automatic two_wire();
        int n;
        sel3 = 5'h0A;
        src = 2'h1;
        max_f = 17'h00014;
        min_f = 17'h00000;
        set_f = 17'h000C8;
        acc_t = 14'h0005;
        dec_t = 14'h0005;
        alt_dec = 14'h0001;
        u_op.set_dir(1'b1, 1'b0);
        wait_freq(17'h0000A);
        for (n = 0; n < 400 && out_freq !== 17'h00014; n++) @(negedge mclk);
        chk(17'(n), 17'h00014);
        chk(out_reverse, 1'b0);
        u_op.set_stop(1'b1);
        u_op.set_dir(1'b1, 1'b1);
        repeat (10) @(negedge mclk);
        chk(run_active, 1'b1);
        u_op.set_dir(1'b0, 1'b0);
        wait_freq(17'h0000A);
        for (n = 0; n < 400 && out_freq !== 17'h00000; n++) @(negedge mclk);
        chk(17'(n), 17'h0000A);
        chk(run_active, 1'b0);
        u_op.set_dir(1'b1, 1'b0);
        wait_run(1'b1);
        tap(stop_key);
        repeat (30) @(negedge mclk);
        chk(run_active, 1'b0);
        u_op.set_dir(1'b0, 1'b0);
        repeat (8) @(negedge mclk);
        u_op.set_dir(1'b1, 1'b0);
        wait_run(1'b1);
        chk(run_active, 1'b1);
        u_op.set_dir(1'b0, 1'b0);
        wait_run(1'b0);
    endtask

    // host holds the output still while the curve voltage is read back
    task automatic curve_pts();
        src = 2'h2;
        max_f = 17'h0012C;
        c_vmax = 13'h07D0;
        c_fbase = 17'h000C8;
        c_vmid = 13'h0190;
        c_fmid = 17'h00064;
        c_vmin = 13'h0064;
        c_fmin = 17'h00032;
        set_f = 17'h00064;
        h_run = 1'b1;
        tap(h_valid);
        wait_freq(17'h00064);
        @(negedge mclk);
        chk(out_voltage, 13'h03E8);
        shape = 1'b1;
        @(negedge mclk);
        chk(out_voltage, 13'h0190);
        set_f = 17'h00096;
        wait_freq(17'h00096);
        @(negedge mclk);
        chk(out_voltage, 13'h04B0);
        c_vmid = 13'h0BB8;
        @(negedge mclk);
        chk(out_voltage, 13'h07D0);
        c_fmid = 17'h0012C;
        @(negedge mclk);
        chk(out_voltage, 13'h0556);
        set_f = 17'h00028;
        wait_freq(17'h00028);
        @(negedge mclk);
        chk(out_voltage, 13'h0064);
        set_f = 17'h000FA;
        wait_freq(17'h000FA);
        @(negedge mclk);
        chk(out_voltage, 13'h07D0);
    endtask

    task automatic close_out();
        if (err_total == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        repeat (10) @(negedge mclk);
        rst = 1'b0;
        chk(out_freq, 17'h00000);
        chk(stop_key_active, 1'b1);
        repeat (5) @(negedge mclk);
        three_wire();
        lockout_keys();
        host_min();
        two_wire();
        curve_pts();
        close_out();
    end

    // about twenty times the expected run length
    initial begin
        #200000;
        err_total++;
        close_out();
    end
endmodule
`default_nettype wire
